//--- verilog/csf_pkg.sv
package csf_pkg;
    localparam logic [28:0] STATUS_ID = 29'h0000_0211;
    localparam logic [28:0] MOTION_CMD_ID = 29'h0000_0111;
    localparam logic [3:0] STATUS_DLC = 4'h8;
    localparam logic [7:0] VST_NORMAL = 8'h00;
    localparam logic [7:0] VST_ESTOP = 8'h01;
    localparam logic [7:0] VST_ABNORMAL = 8'h02;
    localparam logic [7:0] MODE_STANDBY = 8'h00;
    localparam logic [7:0] MODE_HOST = 8'h01;
    localparam logic [7:0] MODE_REMOTE = 8'h03;
    localparam logic [1:0] POS_TOP = 2'h0;
    localparam logic [1:0] POS_MIDDLE = 2'h1;
    localparam logic [1:0] POS_BOTTOM = 2'h2;
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int TX_PERIOD_MS = 20;
    localparam int CMD_TIMEOUT_MS = 500;
    localparam logic [15:0] ANGLE_LIMIT = 16'h2328;
    localparam logic [31:0] ERR_DEFINED_MASK = 32'h0F3F_FF7F;
    localparam int ERR_HOST_LOST_BIT = 9;
    localparam int ERR_REMOTE_LOST_BIT = 2;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_VOLTAGE = 12'h004;
    localparam logic [11:0] ADDR_FAULT = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;
    localparam logic [11:0] ADDR_ERROR = 12'h010;
    localparam int CTRL_TX_EN_BIT = 0;
    localparam int CTRL_HOST_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam logic [15:0] VOLTAGE_RESET = 16'h0000;
    localparam logic [31:0] FAULT_RESET = 32'h0000_0000;
    localparam int ST_VSTATE_LSB = 0;
    localparam int ST_MODE_LSB = 8;
    localparam int ST_ON_BIT = 16;
    localparam int ST_CMD_LOST_BIT = 17;
    localparam int ST_LIGHTS_BIT = 18;
    localparam int ST_PARK_BIT = 19;
    localparam int ST_OBLIQUE_BIT = 20;
    localparam int ST_ARM_BIT = 21;
    localparam int ST_HALT_BIT = 22;

    typedef enum logic [1:0] {
        CSF_STANDBY,
        CSF_HOST,
        CSF_REMOTE
    } csf_mode_t;

    typedef enum logic [1:0] {
        CSF_PWR_OFF,
        CSF_PWR_ARM,
        CSF_PWR_ON
    } csf_pwr_t;
endpackage : csf_pkg

//--- verilog/csf_chassis_status.sv
// Operation
// - Status frames use 29-bit extended identifiers for a 500 kbit/s CAN link.
// - Multi-byte fields go most significant byte first in the frame.
// - Status frame id 0x211, eight data bytes, sent every 20 ms.
// - Byte 0: vehicle state 0x00 normal, 0x01 emergency, 0x02 abnormal.
// - Byte 1: control mode 0x00 standby, 0x01 host, 0x03 remote.
// - Bytes 2-3: battery voltage in tenths of a volt, unsigned.
// - Bytes 4-7: 32-bit error word, byte 4 most significant.
// - Lever top selects host control; middle or bottom selects remote control.
// - Light switch bottom turns lights off, only in remote mode.
// - Avoidance switch middle position is ignored; avoidance unsupported.
// - Avoidance switch bottom selects parking with wheels locked in X.
// - Switched off while parked needs two power presses to restart.
// - Motion switch top: Ackermann, stick speed and angle, spin on right only.
// - Motion switch bottom: oblique motion, angle limited to 90 degrees.
// - Light bottom, wheel bottom, key press starts steering calibration.
// - Light bottom, wheel top, key press stores steering zero point.
// - Key press outside those combinations clears all latched errors.
// - Remote control has top priority and overrides host commands.
// - Standby after power-up; the remote alone never starts the chassis.
// - Emergency stop input halts at once; release leaves emergency mode.
// - Running chassis accepts host commands and reports its state.
// - Error bits read 1 while active; reserved bits read 0.
// - Motion commands id 0x111 are lost after 500 ms without one.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
module csf_chassis_status #(
    parameter int MS_CYCLES = csf_pkg::MS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic remote_online,
    input wire logic [1:0] control_source_lever,
    input wire logic [1:0] light_switch,
    input wire logic [1:0] avoid_park_switch,
    input wire logic motion_switch_bottom,
    input wire logic [1:0] left_wheel,
    input wire logic function_key,
    input wire logic [15:0] left_stick,
    input wire logic [15:0] right_stick,
    input wire logic estop_n,
    input wire logic power_key,
    input wire logic [31:0] fault_flags,
    input wire logic cmd_rx_valid,
    input wire logic cmd_rx_ext,
    input wire logic [28:0] cmd_rx_id,
    output logic chassis_on,
    output logic halt,
    output logic host_cmd_enable,
    output logic lights_on,
    output logic park_lock,
    output logic motion_oblique,
    output logic spin_mode,
    output logic [15:0] drive_speed,
    output logic [15:0] steer_angle,
    output logic calib_start,
    output logic zero_set,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic tx_ext,
    output logic [28:0] tx_id,
    output logic [3:0] tx_dlc,
    output logic [63:0] tx_data
);
    localparam int MS_W = $clog2(MS_CYCLES + 1);
    localparam logic [MS_W-1:0] MS_LAST = MS_W'(MS_CYCLES - 1);
    localparam logic [4:0] PER_LAST = 5'(csf_pkg::TX_PERIOD_MS - 1);
    localparam logic [8:0] LOST_LIMIT = 9'(csf_pkg::CMD_TIMEOUT_MS);

    typedef struct packed {
        logic estop_s1;
        logic estop_s2;
        logic pwr_s1;
        logic pwr_s2;
        logic pwr_d;
        logic fkey_d;
        logic remote_d;
        logic [MS_W-1:0] ms_cnt;
        logic [4:0] per_cnt;
        logic [8:0] lost_cnt;
        logic cmd_lost;
        csf_pkg::csf_pwr_t pwr;
        logic park_off;
        logic [1:0] ctrl;
        logic [15:0] voltage;
        logic [31:0] sw_fault;
        logic [31:0] err;
        csf_pkg::csf_mode_t mode;
        logic lights;
        logic park;
        logic oblique;
        logic spin;
        logic [15:0] speed;
        logic [15:0] angle;
        logic calib;
        logic zero;
        logic tx_valid;
        logic [63:0] tx_data;
        logic [31:0] prdata;
        logic pslverr;
    } csf_state_t;

    csf_state_t st;
    csf_state_t next_st;

    function automatic logic [7:0] csf_mode_code(input csf_pkg::csf_mode_t m);
        case (m)
            csf_pkg::CSF_HOST: csf_mode_code = csf_pkg::MODE_HOST;
            csf_pkg::CSF_REMOTE: csf_mode_code = csf_pkg::MODE_REMOTE;
            default: csf_mode_code = csf_pkg::MODE_STANDBY;
        endcase
    endfunction : csf_mode_code

    logic estop_act;
    logic ms_tick;
    logic pwr_press;
    logic fkey_press;
    logic combo_calib;
    logic combo_zero;
    logic lever_remote;
    logic [7:0] vstate;
    logic [31:0] err_set;
    logic [31:0] err_clr;
    logic [31:0] status_word;
    logic apb_setup;
    logic apb_write;
    logic signed [15:0] right_s;

    always_comb
    begin
        next_st = st;
        estop_act = ~st.estop_s2;
        ms_tick = (st.ms_cnt == MS_LAST);
        pwr_press = st.pwr_s2 & ~st.pwr_d;
        fkey_press = function_key & ~st.fkey_d;
        lever_remote = (control_source_lever != csf_pkg::POS_TOP);
        right_s = right_stick;
        // Estop and power key are used only as synchronised copies; function_key and remote_online are used raw
        next_st.estop_s1 = estop_n;
        next_st.estop_s2 = st.estop_s1;
        next_st.pwr_s1 = power_key;
        next_st.pwr_s2 = st.pwr_s1;
        next_st.pwr_d = st.pwr_s2;
        next_st.fkey_d = function_key;
        next_st.remote_d = remote_online;

        // Free-running millisecond base
        next_st.ms_cnt = ms_tick ? '0 : st.ms_cnt + 1'b1;

        // Command stream watchdog counted in milliseconds
        if (cmd_rx_valid && cmd_rx_ext && cmd_rx_id == csf_pkg::MOTION_CMD_ID)
        begin
            next_st.lost_cnt = '0;
            next_st.cmd_lost = 1'b0;
        end
        else if (ms_tick && !st.cmd_lost)
        begin
            next_st.lost_cnt = st.lost_cnt + 1'b1;
            if (st.lost_cnt == LOST_LIMIT - 9'h001)
            begin
                next_st.cmd_lost = 1'b1;
            end
        end

        // Power sequencing; a park shutdown arms a second press
        case (st.pwr)
            csf_pkg::CSF_PWR_OFF:
            begin
                if (pwr_press)
                begin
                    next_st.pwr = st.park_off ? csf_pkg::CSF_PWR_ARM : csf_pkg::CSF_PWR_ON;
                end
            end
            csf_pkg::CSF_PWR_ARM:
            begin
                if (pwr_press)
                begin
                    next_st.pwr = csf_pkg::CSF_PWR_ON;
                    next_st.park_off = 1'b0;
                end
            end
            csf_pkg::CSF_PWR_ON:
            begin
                if (pwr_press)
                begin
                    next_st.pwr = csf_pkg::CSF_PWR_OFF;
                    next_st.park_off = st.park;
                end
            end
            default: next_st.pwr = csf_pkg::CSF_PWR_OFF;
        endcase

        // Mode selection; with power on, remote wins whenever it is online and its lever asks for it
        if (st.pwr != csf_pkg::CSF_PWR_ON)
        begin
            next_st.mode = csf_pkg::CSF_STANDBY;
        end
        else if (remote_online && lever_remote)
        begin
            next_st.mode = csf_pkg::CSF_REMOTE;
        end
        else if ((!remote_online || !lever_remote) && !st.cmd_lost
                 && st.ctrl[csf_pkg::CTRL_HOST_EN_BIT])
        begin
            next_st.mode = csf_pkg::CSF_HOST;
        end
        else
        begin
            next_st.mode = csf_pkg::CSF_STANDBY;
        end

        // Remote-only functions; avoidance middle position does nothing
        if (st.mode == csf_pkg::CSF_REMOTE)
        begin
            next_st.lights = (light_switch != csf_pkg::POS_BOTTOM);
            next_st.park = (avoid_park_switch == csf_pkg::POS_BOTTOM);
            next_st.oblique = motion_switch_bottom;
        end
        if (st.pwr != csf_pkg::CSF_PWR_ON)
        begin
            next_st.park = 1'b0;
        end

        // Stick mapping; outputs forced to zero on stop or outside remote
        next_st.spin = 1'b0;
        next_st.speed = '0;
        next_st.angle = '0;
        if (st.mode == csf_pkg::CSF_REMOTE && !estop_act && !st.park)
        begin
            next_st.speed = left_stick;
            if (st.oblique)
            begin
                if (right_s > $signed(csf_pkg::ANGLE_LIMIT))
                begin
                    next_st.angle = csf_pkg::ANGLE_LIMIT;
                end
                else if (right_s < -$signed(csf_pkg::ANGLE_LIMIT))
                begin
                    next_st.angle = 16'(-$signed(csf_pkg::ANGLE_LIMIT));
                end
                else
                begin
                    next_st.angle = right_stick;
                end
            end
            else
            begin
                next_st.angle = right_stick;
                next_st.spin = (left_stick == 16'h0000) && (right_stick != 16'h0000);
            end
        end

        // Function key combinations
        combo_calib = (light_switch == csf_pkg::POS_BOTTOM) && (left_wheel == csf_pkg::POS_BOTTOM);
        combo_zero = (light_switch == csf_pkg::POS_BOTTOM) && (left_wheel == csf_pkg::POS_TOP);
        next_st.calib = fkey_press && combo_calib;
        next_st.zero = fkey_press && combo_zero;
        err_clr = (fkey_press && !combo_calib && !combo_zero) ? '1 : '0;

        // Error latch; a new fault in the clear cycle survives
        err_set = fault_flags | st.sw_fault;
        if (!st.cmd_lost && next_st.cmd_lost && st.mode == csf_pkg::CSF_HOST)
        begin
            err_set[csf_pkg::ERR_HOST_LOST_BIT] = 1'b1;
        end
        if (st.remote_d && !remote_online && st.mode == csf_pkg::CSF_REMOTE)
        begin
            err_set[csf_pkg::ERR_REMOTE_LOST_BIT] = 1'b1;
        end
        next_st.err = ((st.err & ~err_clr) | err_set) & csf_pkg::ERR_DEFINED_MASK;

        if (estop_act)
        begin
            vstate = csf_pkg::VST_ESTOP;
        end
        else if (st.err != 32'h0000_0000)
        begin
            vstate = csf_pkg::VST_ABNORMAL;
        end
        else
        begin
            vstate = csf_pkg::VST_NORMAL;
        end

        // Period timer; a frame still waiting at expiry skips this slot
        if (ms_tick)
        begin
            next_st.per_cnt = (st.per_cnt == PER_LAST) ? 5'h00 : st.per_cnt + 5'h01;
        end
        if (tx_valid && tx_ready)
        begin
            next_st.tx_valid = 1'b0;
        end
        if (ms_tick && st.per_cnt == PER_LAST && !st.tx_valid
            && st.ctrl[csf_pkg::CTRL_TX_EN_BIT])
        begin
            next_st.tx_valid = 1'b1;
            next_st.tx_data = {vstate, csf_mode_code(st.mode), st.voltage, st.err};
        end

        status_word = '0;
        status_word[csf_pkg::ST_VSTATE_LSB +: 8] = vstate;
        status_word[csf_pkg::ST_MODE_LSB +: 8] = csf_mode_code(st.mode);
        status_word[csf_pkg::ST_ON_BIT] = (st.pwr == csf_pkg::CSF_PWR_ON);
        status_word[csf_pkg::ST_CMD_LOST_BIT] = st.cmd_lost;
        status_word[csf_pkg::ST_LIGHTS_BIT] = st.lights;
        status_word[csf_pkg::ST_PARK_BIT] = st.park;
        status_word[csf_pkg::ST_OBLIQUE_BIT] = st.oblique;
        status_word[csf_pkg::ST_ARM_BIT] = (st.pwr == csf_pkg::CSF_PWR_ARM);
        status_word[csf_pkg::ST_HALT_BIT] = estop_act;

        // APB: read data captured in setup so it is steady in access
        apb_setup = psel && !penable;
        apb_write = psel && penable && pwrite;
        if (apb_setup)
        begin
            next_st.prdata = '0;
            next_st.pslverr = 1'b0;
            case (paddr)
                csf_pkg::ADDR_CTRL: next_st.prdata = {30'h0000_0000, st.ctrl};
                csf_pkg::ADDR_VOLTAGE: next_st.prdata = {16'h0000, st.voltage};
                csf_pkg::ADDR_FAULT: next_st.prdata = st.sw_fault;
                csf_pkg::ADDR_STATUS: next_st.prdata = status_word;
                csf_pkg::ADDR_ERROR: next_st.prdata = st.err;
                default: next_st.pslverr = 1'b1;
            endcase
        end
        if (apb_write)
        begin
            case (paddr)
                csf_pkg::ADDR_CTRL: next_st.ctrl = pwdata[1:0];
                csf_pkg::ADDR_VOLTAGE: next_st.voltage = pwdata[15:0];
                csf_pkg::ADDR_FAULT: next_st.sw_fault = pwdata & csf_pkg::ERR_DEFINED_MASK;
                default: next_st.ctrl = st.ctrl;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st.estop_s1 <= 1'b0;
            st.estop_s2 <= 1'b0;
            st.pwr_s1 <= 1'b0;
            st.pwr_s2 <= 1'b0;
            st.pwr_d <= 1'b0;
            st.fkey_d <= 1'b0;
            st.remote_d <= 1'b0;
            st.ms_cnt <= '0;
            st.per_cnt <= 5'h00;
            st.lost_cnt <= 9'h000;
            st.cmd_lost <= 1'b1;
            st.pwr <= csf_pkg::CSF_PWR_OFF;
            st.park_off <= 1'b0;
            st.ctrl <= csf_pkg::CTRL_RESET;
            st.voltage <= csf_pkg::VOLTAGE_RESET;
            st.sw_fault <= csf_pkg::FAULT_RESET;
            st.err <= 32'h0000_0000;
            st.mode <= csf_pkg::CSF_STANDBY;
            st.lights <= 1'b1;
            st.park <= 1'b0;
            st.oblique <= 1'b0;
            st.spin <= 1'b0;
            st.speed <= 16'h0000;
            st.angle <= 16'h0000;
            st.calib <= 1'b0;
            st.zero <= 1'b0;
            st.tx_valid <= 1'b0;
            st.tx_data <= 64'h0000_0000_0000_0000;
            st.prdata <= 32'h0000_0000;
            st.pslverr <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = 1'b1;
    assign pslverr = st.pslverr;
    assign chassis_on = (st.pwr == csf_pkg::CSF_PWR_ON);
    // Stop path is combinational after the synchroniser for minimum latency
    assign halt = ~st.estop_s2;
    // Mode lags power by one edge, so power is gated here too
    assign host_cmd_enable = (st.mode == csf_pkg::CSF_HOST) && st.estop_s2 && chassis_on;
    assign lights_on = st.lights;
    assign park_lock = st.park;
    assign motion_oblique = st.oblique;
    assign spin_mode = st.spin;
    assign drive_speed = st.speed;
    assign steer_angle = st.angle;
    assign calib_start = st.calib;
    assign zero_set = st.zero;
    assign tx_valid = st.tx_valid;
    assign tx_ext = 1'b1;
    assign tx_id = csf_pkg::STATUS_ID;
    assign tx_dlc = csf_pkg::STATUS_DLC;
    assign tx_data = st.tx_data;
endmodule : csf_chassis_status

//--- testbench/csf_chassis_status_checker.sv
`timescale 1ns/1ps
module csf_chassis_status_checker #(
    parameter int MS_CYCLES = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic remote_online,
    input wire logic [1:0] control_source_lever,
    input wire logic [1:0] light_switch,
    input wire logic [1:0] left_wheel,
    input wire logic estop_n,
    input wire logic chassis_on,
    input wire logic halt,
    input wire logic host_cmd_enable,
    input wire logic lights_on,
    input wire logic calib_start,
    input wire logic zero_set,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_ext,
    input wire logic [28:0] tx_id,
    input wire logic [3:0] tx_dlc,
    input wire logic [63:0] tx_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    localparam int PERIOD = 20 * MS_CYCLES;
    logic tx_q;
    logic seen;
    logic [31:0] cnt;
    // Skipped slots would break this; the partner never stalls a period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_q <= 1'b0;
            seen <= 1'b0;
            cnt <= 32'h0000_0000;
        end
        else
        begin
            tx_q <= tx_valid;
            cnt <= (tx_valid && !tx_q) ? 32'h0000_0000 : cnt + 32'h0000_0001;
            seen <= seen | (tx_valid && !tx_q);
        end
    end
    sequence s_pend;
        tx_valid && !tx_ready;
    endsequence
    sequence s_take;
        tx_valid && tx_ready;
    endsequence
    chk_frame_const: assert property (tx_valid |-> tx_ext && tx_id == csf_pkg::STATUS_ID
        && tx_dlc == csf_pkg::STATUS_DLC) else $error("frame header wrong");
    chk_frame_hold: assert property (s_pend |=> tx_valid && $stable(tx_data))
        else $error("frame changed while pending");
    chk_frame_done: assert property (s_take |=> !tx_valid) else $error("frame not released");
    chk_frame_period: assert property (tx_valid && !tx_q && seen |-> cnt == PERIOD - 1)
        else $error("frame period wrong");
    chk_estop_halt: assert property (!estop_n [*3] |-> halt) else $error("stop not halting");
    chk_estop_release: assert property (estop_n [*3] |-> !halt) else $error("halt stuck");
    chk_host_gate: assert property (host_cmd_enable |-> chassis_on && !halt)
        else $error("host enabled wrongly");
    chk_remote_first: assert property ((remote_online
        && control_source_lever != csf_pkg::POS_TOP) [*2] |-> !host_cmd_enable)
        else $error("host overrides remote");
    chk_calib_combo: assert property (calib_start |-> light_switch == csf_pkg::POS_BOTTOM
        && left_wheel == csf_pkg::POS_BOTTOM ##1 !calib_start) else $error("calib pulse wrong");
    chk_zero_combo: assert property (zero_set |-> light_switch == csf_pkg::POS_BOTTOM
        && left_wheel == csf_pkg::POS_TOP ##1 !zero_set) else $error("zero pulse wrong");
    chk_lights_off: assert property ($fell(lights_on) |-> $past(light_switch) ==
        csf_pkg::POS_BOTTOM) else $error("lights off without switch");
endmodule : csf_chassis_status_checker
bind csf_chassis_status csf_chassis_status_checker #(.MS_CYCLES(MS_CYCLES)) csf_chk_inst (.*);

//--- testbench/csf_host_model.sv
`timescale 1ns/1ps
module csf_host_model #(
    parameter int MS_CYCLES = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic send_cmd,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic cmd_rx_valid,
    output logic cmd_rx_ext,
    output logic [28:0] cmd_rx_id
);
    int wait_n;
    int cmd_n;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_ready <= 1'b0;
            wait_n <= 0;
            cmd_n <= 0;
            cmd_rx_valid <= 1'b0;
            cmd_rx_ext <= 1'b0;
            cmd_rx_id <= 29'h0000_0000;
        end
        else
        begin
            // Slow mode stalls five cycles, well inside one period
            wait_n <= (tx_valid && !tx_ready) ? wait_n + 1 : 0;
            tx_ready <= tx_valid && !tx_ready && (!slow || wait_n >= 4);
            cmd_n <= (cmd_n == 20 * MS_CYCLES - 1) ? 0 : cmd_n + 1;
            cmd_rx_valid <= send_cmd && cmd_n == 0;
            cmd_rx_ext <= 1'b1;
            // Id toggles between notices; a stale id equals the motion id every other cycle
            cmd_rx_id <= (send_cmd && cmd_n == 0) ? csf_pkg::MOTION_CMD_ID : ~cmd_rx_id;
        end
    end
endmodule : csf_host_model

//--- testbench/csf_chassis_status_tb.sv
`timescale 1ns/1ps
module csf_chassis_status_tb;
    localparam int MS = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic remote_online = 1'b0;
    logic [1:0] control_source_lever = 2'h0;
    logic [1:0] light_switch = 2'h0, avoid_park_switch = 2'h0;
    logic motion_switch_bottom = 1'b0;
    logic [1:0] left_wheel = 2'h1;
    logic function_key = 1'b0;
    logic [15:0] left_stick = 16'h0000, right_stick = 16'h0000;
    logic estop_n = 1'b1, power_key = 1'b0;
    logic [31:0] fault_flags = 32'h0000_0000;
    logic slow = 1'b0, send_cmd = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, cmd_rx_valid, cmd_rx_ext, chassis_on, halt, host_cmd_enable;
    logic lights_on, park_lock, motion_oblique, spin_mode, calib_start, zero_set;
    logic tx_valid, tx_ready, tx_ext;
    logic [28:0] cmd_rx_id, tx_id;
    logic [15:0] drive_speed, steer_angle;
    logic [3:0] tx_dlc;
    logic [63:0] tx_data;
    logic [31:0] rd;
    logic er;
    logic [1:0] pulses;
    int n_fail = 0;
    int check_count = 0;
    always #50 pclk = ~pclk;
    csf_chassis_status #(.MS_CYCLES(MS)) csf_chassis_status_inst (.*);
    csf_host_model #(.MS_CYCLES(MS)) csf_host_model_inst (.*);
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic hang();
        n_fail++;
        $display("mismatch wait expected answer seen none");
        print_verdict();
    endtask : hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16)
            hang();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        apb(1'b0, a, 32'h0000_0000);
        chk("prdata", exp, rd);
        chk("pslverr", eerr, er);
    endtask : rdc
    // Second handshake only: the first may carry state sampled before the change
    task automatic frame(input logic [63:0] exp);
        int i;
        repeat (2)
        begin
            for (i = 0; i < 600; i++)
            begin
                @(posedge pclk);
                if (tx_valid === 1'b1 && tx_ready === 1'b1)
                    break;
            end
            if (i == 600)
                hang();
        end
        chk("tx_data", exp, tx_data);
    endtask : frame
    task automatic key();
        function_key <= 1'b1;
        pulses = 2'b00;
        repeat (4)
        begin
            @(posedge pclk);
            pulses = pulses | {calib_start, zero_set};
        end
        function_key <= 1'b0;
        tick(4);
    endtask : key
    task automatic pwr();
        power_key <= 1'b1;
        tick(6);
        power_key <= 1'b0;
        tick(6);
    endtask : pwr
    initial
    begin
        tick(8);
        presetn <= 1'b1;
        tick(1);
        rdc(csf_pkg::ADDR_CTRL, 32'h0000_0003, 1'b0);
        rdc(csf_pkg::ADDR_VOLTAGE, 32'h0000_0000, 1'b0);
        rdc(csf_pkg::ADDR_ERROR, 32'h0000_0000, 1'b0);
        rdc(12'h014, 32'h0000_0000, 1'b1);
        apb(1'b1, csf_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        rdc(csf_pkg::ADDR_STATUS, 32'h0006_0000, 1'b0);
        remote_online <= 1'b1;
        control_source_lever <= csf_pkg::POS_MIDDLE;
        frame(64'h0000_0000_0000_0000);
        chk("chassis_on", 1'b0, chassis_on);
        $display("end reset test");
        slow <= 1'b1;
        apb(1'b1, csf_pkg::ADDR_VOLTAGE, 32'h0000_01E0);
        pwr();
        chk("chassis_on", 1'b1, chassis_on);
        frame(64'h0003_01E0_0000_0000);
        light_switch <= csf_pkg::POS_BOTTOM;
        left_wheel <= csf_pkg::POS_BOTTOM;
        tick(4);
        chk("lights_on", 1'b0, lights_on);
        key();
        chk("calib", 2'b10, pulses);
        left_wheel <= csf_pkg::POS_TOP;
        tick(1);
        key();
        chk("zero", 2'b01, pulses);
        light_switch <= csf_pkg::POS_TOP;
        right_stick <= 16'd500;
        tick(4);
        chk("spin_mode", 1'b1, spin_mode);
        motion_switch_bottom <= 1'b1;
        right_stick <= 16'd12000;
        left_stick <= 16'd100;
        avoid_park_switch <= csf_pkg::POS_MIDDLE;
        tick(4);
        chk("steer_angle", csf_pkg::ANGLE_LIMIT, steer_angle);
        chk("motion_oblique", 1'b1, motion_oblique);
        chk("park_lock", 1'b0, park_lock);
        chk("drive_moving", 1'b1, drive_speed != 16'h0000);
        avoid_park_switch <= csf_pkg::POS_BOTTOM;
        tick(4);
        chk("park_lock", 1'b1, park_lock);
        chk("drive_speed", 16'h0000, drive_speed);
        pwr();
        chk("chassis_on", 1'b0, chassis_on);
        pwr();
        chk("chassis_on", 1'b0, chassis_on);
        pwr();
        chk("chassis_on", 1'b1, chassis_on);
        avoid_park_switch <= csf_pkg::POS_TOP;
        motion_switch_bottom <= 1'b0;
        left_stick <= 16'h0000;
        right_stick <= 16'h0000;
        $display("end remote test");
        slow <= 1'b0;
        send_cmd <= 1'b1;
        control_source_lever <= csf_pkg::POS_TOP;
        frame(64'h0001_01E0_0000_0000);
        chk("host_cmd_enable", 1'b1, host_cmd_enable);
        control_source_lever <= csf_pkg::POS_BOTTOM;
        frame(64'h0003_01E0_0000_0000);
        control_source_lever <= csf_pkg::POS_TOP;
        tick(10);
        send_cmd <= 1'b0;
        tick(5400);
        rdc(csf_pkg::ADDR_ERROR, 32'h0000_0200, 1'b0);
        frame(64'h0200_01E0_0000_0200);
        $display("end host test");
        apb(1'b1, csf_pkg::ADDR_FAULT, 32'hFFFF_FFFF);
        rdc(csf_pkg::ADDR_FAULT, 32'h0F3F_FF7F, 1'b0);
        rdc(csf_pkg::ADDR_ERROR, 32'h0F3F_FF7F, 1'b0);
        apb(1'b1, csf_pkg::ADDR_FAULT, 32'h0000_0000);
        key();
        chk("pulses", 2'b00, pulses);
        rdc(csf_pkg::ADDR_ERROR, 32'h0000_0000, 1'b0);
        frame(64'h0000_01E0_0000_0000);
        $display("end fault test");
        estop_n <= 1'b0;
        tick(4);
        chk("halt", 1'b1, halt);
        frame(64'h0100_01E0_0000_0000);
        estop_n <= 1'b1;
        tick(4);
        chk("halt", 1'b0, halt);
        $display("end stop test");
        print_verdict();
    end
endmodule : csf_chassis_status_tb
